/* rtl/pldc_pkg.sv */
// Package for the quick link drop configuration register bank
package pldc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FAST_DROP_CONFIG    = 8'h2d;
    localparam logic [7:0] IDX_FAST_DROP_THRESHOLD = 8'h2e;
    localparam logic [7:0] IDX_GENERAL_CONFIG_FOUR = 8'h31;
    localparam logic [7:0] IDX_MAC_PORT_CONTROL    = 8'h32;
    localparam logic [7:0] IDX_IRQ_STATUS          = 8'h3a;
    localparam logic [7:0] IDX_IRQ_MASK            = 8'h3b;

    // Field positions
    localparam int FORCE_DROP_BIT   = 15;
    localparam int DROP_ENABLE_BIT  = 14;
    localparam int CAUSE_LSB        = 8;
    localparam int SOURCE_LSB       = 0;
    localparam int THR_RSVD_HI_LSB  = 8;
    localparam int THR_RSVD_LO_LSB  = 4;
    localparam int ENERGY_THR_LSB   = 0;
    localparam int GENERAL_CONFIG_FOUR_ONE_BIT     = 12;
    localparam int GENERAL_CONFIG_FOUR_RSVD_RW_BIT = 8;
    localparam int TEST_ENTRY_BIT   = 7;
    localparam int NEG_TIMER_LSB    = 5;
    localparam int GENERAL_CONFIG_FOUR_FIXED_LSB   = 1;
    localparam int MIRROR_BIT       = 0;
    localparam int MAC_ENABLE_BIT   = 7;
    localparam int RX_MID_LSB       = 5;
    localparam int TX_MID_LSB       = 3;

    // Values after reset and fixed read patterns
    localparam logic [2:0] RST_ENERGY_THR       = 3'h1;
    localparam logic [2:0] RST_ENERGY_THR_STRAP = 3'h2;
    localparam logic [2:0] RST_THR_RSVD         = 3'h2;
    localparam logic [1:0] RST_NEG_TIMER        = 2'h1;
    localparam logic [1:0] RST_FIFO_MID         = 2'h2;
    localparam logic       RST_MAC_ENABLE       = 1'h1;
    localparam logic [3:0] GENERAL_CONFIG_FOUR_FIXED           = 4'h8;

    // Receive-control strap modes that request internal test mode
    localparam logic [1:0] RXC_MODE1 = 2'h1;
    localparam logic [1:0] RXC_MODE2 = 2'h2;

    // Negotiation timer selections
    localparam logic [1:0] NEG_SEL_16MS  = 2'h0;
    localparam logic [1:0] NEG_SEL_2US   = 2'h1;
    localparam logic [1:0] NEG_SEL_800US = 2'h2;
    localparam logic [1:0] NEG_SEL_11MS  = 2'h3;

    // Times and clock rate
    localparam int CLK_MHZ     = 10;
    localparam int T_2US_US    = 2;
    localparam int T_800US_US  = 800;
    localparam int T_11MS_US   = 11000;
    localparam int T_16MS_US   = 16000;
    localparam int CYC_2US     = T_2US_US * CLK_MHZ;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // Detector inputs from the link monitors
    typedef struct packed {
        logic       desync_loss;
        logic       rx_errors;
        logic       mlt3_errors;
        logic       snr_low;
        logic       no_signal;
        logic [7:0] energy_acc;
    } pldc_det_type;

    // Strap pins
    typedef struct packed {
        logic [1:0] rx_ctrl;
        logic       mirror;
        logic       mac_enable;
        logic       drop_enable;
    } pldc_strap_type;

    // Whole state of the register bank
    typedef struct packed {
        pldc_strap_type strap_s1;
        pldc_strap_type strap_s2;
        logic [1:0]     settle;
        logic           strap_done;
        logic           test_req;
        logic           force_drop;
        logic           drop_enable;
        logic [4:0]     cause;
        logic [4:0]     source_mask;
        logic [2:0]     thr_rsvd_hi;
        logic [2:0]     thr_rsvd_lo;
        logic [2:0]     energy_thr;
        logic           general_config_four_rsvd;
        logic           test_entry;
        logic [1:0]     neg_sel;
        logic           mirror;
        logic           mac_enable;
        logic [1:0]     rx_mid;
        logic [1:0]     tx_mid;
        logic [5:0]     irq_sts;
        logic [5:0]     irq_msk;
        logic [31:0]    prdata;
        logic           pslverr;
        logic [17:0]    tmr_cnt;
        logic           tmr_done;
        logic           drop;
    } pldc_state_type;

    localparam pldc_state_type RST_STATE = '{
        thr_rsvd_hi: RST_THR_RSVD,
        thr_rsvd_lo: RST_THR_RSVD,
        energy_thr:  RST_ENERGY_THR,
        neg_sel:     RST_NEG_TIMER,
        mac_enable:  RST_MAC_ENABLE,
        rx_mid:      RST_FIFO_MID,
        tx_mid:      RST_FIFO_MID,
        default:     '0
    };

endpackage

/* rtl/pldc_regs.sv */
// Quick link drop and port configuration registers behind an APB slave
//
// Contract
// - Force-drop bit set drops the link whenever no signal is received.
// - Cause flags latch high when an enabled criterion drops the link.
// - Each of five drop sources is enabled by its own mask bit.
// - Energy-loss criterion asserts when accumulator is below threshold.
// - Strap-enabled quick drop resets threshold to two; software rewrites.
// - Receive-control strap mode1 or mode2 sets internal test entry bit.
// - Low test request output shows the strap asked for test entry.
// - Negotiation timer field selects 16 ms, 2 us, 800 us or 11 ms.
// - Config four bits 4 to 1 ignore writes and read as 1000.
// - Port-mirror bit enables mirroring; reset value comes from a strap.
// - MAC interface enable bit; resets to one or to its strap.
// - Two-bit receive FIFO mid-level threshold, reset value 10.
// - Two-bit transmit FIFO mid-level threshold, reset value 10.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module pldc_regs #(
    parameter int unsigned CYC_800US = pldc_pkg::T_800US_US * pldc_pkg::CLK_MHZ,
    parameter int unsigned CYC_11MS  = pldc_pkg::T_11MS_US * pldc_pkg::CLK_MHZ,
    parameter int unsigned CYC_16MS  = pldc_pkg::T_16MS_US * pldc_pkg::CLK_MHZ,
    parameter bit          MAC_EN_STRAPPED = 1'b0
) (
    // Clock and reset
    input  wire logic                     mclk_i,
    input  wire logic                     nrst_i,
    // APB slave
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [9:0]               paddr_i,
    input  wire logic [31:0]              pwdata_i,
    input  wire logic [3:0]               pstrb_i,
    output logic      [31:0]              prdata_o,
    output logic                          pready_o,
    output logic                          pslverr_o,
    // Link detectors and straps
    input  wire pldc_pkg::pldc_det_type   det_i,
    input  wire pldc_pkg::pldc_strap_type strap_i,
    input  wire logic                     neg_timer_start_i,
    // Controls towards the PHY core
    output logic                          link_drop_o,
    output logic                          int_test_mode_o,
    output logic                          test_entry_req_n_o,
    output logic                          port_mirror_o,
    output logic                          mac_if_enable_o,
    output logic      [1:0]               rx_fifo_mid_level_o,
    output logic      [1:0]               tx_fifo_mid_level_o,
    output logic                          neg_timer_done_o,
    // Interrupt
    output logic                          irq_o
);

    localparam int TMR_2US_CHECK = pldc_pkg::CYC_2US;

    pldc_pkg::pldc_state_type s;
    pldc_pkg::pldc_state_type n;

    logic        setup;
    logic        access;
    logic [7:0]  idx;
    logic        mapped;
    logic [15:0] rval;
    logic [15:0] wval;
    logic        energy_low;
    logic [4:0]  crit;
    logic [4:0]  hit;

    // Strap modes that ask for internal test entry
    function automatic logic rxc_test(input logic [1:0] rx);
        rxc_test = (rx == pldc_pkg::RXC_MODE1) || (rx == pldc_pkg::RXC_MODE2);
    endfunction

    // Decode of implemented register indices
    function automatic logic is_mapped(input logic [7:0] i);
        case (i)
            pldc_pkg::IDX_FAST_DROP_CONFIG,
            pldc_pkg::IDX_FAST_DROP_THRESHOLD,
            pldc_pkg::IDX_GENERAL_CONFIG_FOUR,
            pldc_pkg::IDX_MAC_PORT_CONTROL,
            pldc_pkg::IDX_IRQ_STATUS,
            pldc_pkg::IDX_IRQ_MASK: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Timer length in cycles for a selection
    function automatic logic [17:0] tmr_len(input logic [1:0] sel);
        case (sel)
            pldc_pkg::NEG_SEL_2US:   tmr_len = 18'(pldc_pkg::CYC_2US);
            pldc_pkg::NEG_SEL_800US: tmr_len = 18'(CYC_800US);
            pldc_pkg::NEG_SEL_11MS:  tmr_len = 18'(CYC_11MS);
            default:                 tmr_len = 18'(CYC_16MS);
        endcase
    endfunction

    // Read view of one register; bits with no field read as zero
    function automatic logic [15:0] rd16(input logic [7:0] i,
                                         input pldc_pkg::pldc_state_type st);
        logic [15:0] v;
        v = 16'h0000;
        case (i)
            pldc_pkg::IDX_FAST_DROP_CONFIG: begin
                v[pldc_pkg::FORCE_DROP_BIT]       = st.force_drop;
                v[pldc_pkg::DROP_ENABLE_BIT]      = st.drop_enable;
                v[pldc_pkg::CAUSE_LSB +: 5]       = st.cause;
                v[pldc_pkg::SOURCE_LSB +: 5]      = st.source_mask;
            end
            pldc_pkg::IDX_FAST_DROP_THRESHOLD: begin
                v[pldc_pkg::THR_RSVD_HI_LSB +: 3] = st.thr_rsvd_hi;
                v[pldc_pkg::THR_RSVD_LO_LSB +: 3] = st.thr_rsvd_lo;
                v[pldc_pkg::ENERGY_THR_LSB +: 3]  = st.energy_thr;
            end
            pldc_pkg::IDX_GENERAL_CONFIG_FOUR: begin
                v[pldc_pkg::GENERAL_CONFIG_FOUR_ONE_BIT]         = 1'b1;
                v[pldc_pkg::GENERAL_CONFIG_FOUR_RSVD_RW_BIT]     = st.general_config_four_rsvd;
                v[pldc_pkg::TEST_ENTRY_BIT]       = st.test_entry;
                v[pldc_pkg::NEG_TIMER_LSB +: 2]   = st.neg_sel;
                v[pldc_pkg::GENERAL_CONFIG_FOUR_FIXED_LSB +: 4]  = pldc_pkg::GENERAL_CONFIG_FOUR_FIXED;
                v[pldc_pkg::MIRROR_BIT]           = st.mirror;
            end
            pldc_pkg::IDX_MAC_PORT_CONTROL: begin
                v[pldc_pkg::MAC_ENABLE_BIT]       = st.mac_enable;
                v[pldc_pkg::RX_MID_LSB +: 2]      = st.rx_mid;
                v[pldc_pkg::TX_MID_LSB +: 2]      = st.tx_mid;
            end
            pldc_pkg::IDX_IRQ_STATUS: v[5:0] = st.irq_sts;
            pldc_pkg::IDX_IRQ_MASK:   v[5:0] = st.irq_msk;
            default:                  v = 16'h0000;
        endcase
        rd16 = v;
    endfunction

    // Byte-lane merge of write data over the current value
    function automatic logic [15:0] wmerge(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0]  strb);
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            v[15:8] = wd[15:8];
        end
        wmerge = v;
    endfunction

    // Bus phase decode
    assign setup  = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign idx    = paddr_i[9:2];
    assign mapped = (paddr_i[1:0] == 2'b00) && is_mapped(idx);
    assign rval   = rd16(idx, s);
    assign wval   = wmerge(rval, pwdata_i[15:0], pstrb_i[1:0]);

    assign energy_low = det_i.energy_acc < {5'h00, s.energy_thr};
    assign crit = {det_i.desync_loss, det_i.rx_errors, det_i.mlt3_errors,
                   det_i.snr_low, energy_low};
    assign hit = s.drop_enable ? (crit & s.source_mask) : 5'h00;

    // Next-state logic
    always_comb begin
        n = s;
        // Two-stage strap synchroniser
        n.strap_s1 = strap_i;
        n.strap_s2 = s.strap_s1;

        // Straps taken once, after the synchroniser has settled
        if (!s.strap_done) begin
            if (s.settle == pldc_pkg::STRAP_SETTLE) begin
                n.strap_done = 1'b1;
                n.test_req   = rxc_test(s.strap_s2.rx_ctrl);
                n.test_entry = rxc_test(s.strap_s2.rx_ctrl);
                n.mirror     = s.strap_s2.mirror;
                if (MAC_EN_STRAPPED) begin
                    n.mac_enable = s.strap_s2.mac_enable;
                end
                if (s.strap_s2.drop_enable) begin
                    n.energy_thr = pldc_pkg::RST_ENERGY_THR_STRAP;
                end
            end else begin
                n.settle = s.settle + 2'h1;
            end
        end

        // Read data and error captured in setup, shown in access
        if (setup) begin
            n.prdata  = {16'h0000, (mapped && !pwrite_i) ? rval : 16'h0000};
            n.pslverr = !mapped;
        end

        // Register writes on the access cycle
        if (access && pwrite_i && mapped) begin
            case (idx)
                pldc_pkg::IDX_FAST_DROP_CONFIG: begin
                    n.force_drop  = wval[pldc_pkg::FORCE_DROP_BIT];
                    n.drop_enable = wval[pldc_pkg::DROP_ENABLE_BIT];
                    n.source_mask = wval[pldc_pkg::SOURCE_LSB +: 5];
                end
                pldc_pkg::IDX_FAST_DROP_THRESHOLD: begin
                    n.thr_rsvd_hi = wval[pldc_pkg::THR_RSVD_HI_LSB +: 3];
                    n.thr_rsvd_lo = wval[pldc_pkg::THR_RSVD_LO_LSB +: 3];
                    n.energy_thr  = wval[pldc_pkg::ENERGY_THR_LSB +: 3];
                end
                pldc_pkg::IDX_GENERAL_CONFIG_FOUR: begin
                    n.general_config_four_rsvd  = wval[pldc_pkg::GENERAL_CONFIG_FOUR_RSVD_RW_BIT];
                    n.test_entry = wval[pldc_pkg::TEST_ENTRY_BIT];
                    n.neg_sel    = wval[pldc_pkg::NEG_TIMER_LSB +: 2];
                    n.mirror     = wval[pldc_pkg::MIRROR_BIT];
                end
                pldc_pkg::IDX_MAC_PORT_CONTROL: begin
                    n.mac_enable = wval[pldc_pkg::MAC_ENABLE_BIT];
                    n.rx_mid     = wval[pldc_pkg::RX_MID_LSB +: 2];
                    n.tx_mid     = wval[pldc_pkg::TX_MID_LSB +: 2];
                end
                pldc_pkg::IDX_IRQ_MASK: n.irq_msk = wval[5:0];
                default: n.irq_msk = s.irq_msk;
            endcase
        end

        // clear on read only what the read returned
        if (access && !pwrite_i && mapped) begin
            if (idx == pldc_pkg::IDX_FAST_DROP_CONFIG) begin
                n.cause = s.cause & ~s.prdata[pldc_pkg::CAUSE_LSB +: 5];
            end
            if (idx == pldc_pkg::IDX_IRQ_STATUS) begin
                n.irq_sts = s.irq_sts & ~s.prdata[5:0];
            end
        end

        // latch causes; a set wins over a clear
        n.cause   = n.cause | hit;
        n.irq_sts = n.irq_sts | {s.tmr_done, hit};

        // negotiation timer, restarted by each start pulse
        if (neg_timer_start_i) begin
            n.tmr_cnt = tmr_len(s.neg_sel);
        end else if (s.tmr_cnt != 18'h00000) begin
            n.tmr_cnt = s.tmr_cnt - 18'h00001;
        end
        n.tmr_done = !neg_timer_start_i && (s.tmr_cnt == 18'h00001);

        // drop when forced and no signal, or on an enabled cause
        n.drop = (|hit) || (s.force_drop && det_i.no_signal);
    end

    // State register; strap-dependent values are loaded after release
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= pldc_pkg::RST_STATE;
        end else begin
            s <= n;
        end
    end

    // Outputs
    assign prdata_o            = s.prdata;
    assign pready_o            = access;   // Zero wait states
    assign pslverr_o           = access && s.pslverr;
    assign link_drop_o         = s.drop;
    assign int_test_mode_o     = s.test_entry;
    assign test_entry_req_n_o  = !s.test_req;
    assign port_mirror_o       = s.mirror;
    assign mac_if_enable_o     = s.mac_enable;
    assign rx_fifo_mid_level_o = s.rx_mid;
    assign tx_fifo_mid_level_o = s.tx_mid;
    assign neg_timer_done_o    = s.tmr_done;
    // Level interrupt from unmasked sticky events
    assign irq_o               = |(s.irq_sts & s.irq_msk);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    property p_force_drop;
        (s.force_drop && det_i.no_signal) |=> link_drop_o;
    endproperty
    a_force_drop: assert property (p_force_drop)
        else $error("forced drop missing");

    property p_cause_latch;
        (hit != 5'h00) |=> ((s.cause & $past(hit)) == $past(hit));
    endproperty
    a_cause_latch: assert property (p_cause_latch)
        else $error("cause flag not latched");

    property p_source_gate;
        ((crit & s.source_mask) == 5'h00
            && !(s.force_drop && det_i.no_signal)) |=> !link_drop_o;
    endproperty
    a_source_gate: assert property (p_source_gate)
        else $error("drop from disabled source");

    property p_energy;
        (s.drop_enable && s.source_mask[0] && energy_low)
            |=> (link_drop_o && s.cause[0]);
    endproperty
    a_energy: assert property (p_energy)
        else $error("energy loss not acted on");

    property p_strap_thr;
        ($rose(s.strap_done) && $past(s.strap_s2.drop_enable))
            |-> (s.energy_thr == 3'h2);
    endproperty
    a_strap_thr: assert property (p_strap_thr)
        else $error("strap threshold wrong");

    property p_strap_test;
        $rose(s.strap_done)
            |-> (int_test_mode_o == rxc_test($past(s.strap_s2.rx_ctrl)));
    endproperty
    a_strap_test: assert property (p_strap_test)
        else $error("test entry not taken from strap");

    property p_test_req;
        $rose(s.strap_done) |-> (test_entry_req_n_o
            == !rxc_test($past(s.strap_s2.rx_ctrl)));
    endproperty
    a_test_req: assert property (p_test_req)
        else $error("test request output wrong");

    property p_timer;
        (neg_timer_start_i && s.neg_sel == pldc_pkg::NEG_SEL_2US)
            |=> (s.tmr_cnt == 18'(TMR_2US_CHECK));
    endproperty
    a_timer: assert property (p_timer)
        else $error("timer length wrong");

    property p_general_config_four_fixed;
        (setup && !pwrite_i && idx == pldc_pkg::IDX_GENERAL_CONFIG_FOUR
            && paddr_i[1:0] == 2'b00) |=> (prdata_o[4:1] == 4'h8);
    endproperty
    a_general_config_four_fixed: assert property (p_general_config_four_fixed)
        else $error("fixed field not 1000");

    property p_mirror;
        (access && pwrite_i && mapped && pstrb_i[0]
            && idx == pldc_pkg::IDX_GENERAL_CONFIG_FOUR)
            |=> (port_mirror_o == $past(pwdata_i[0]));
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("mirror write lost");

    property p_mac_en;
        (access && pwrite_i && mapped && pstrb_i[0]
            && idx == pldc_pkg::IDX_MAC_PORT_CONTROL)
            |=> (mac_if_enable_o == $past(pwdata_i[7]));
    endproperty
    a_mac_en: assert property (p_mac_en)
        else $error("interface enable write lost");

    property p_rx_mid;
        (access && pwrite_i && mapped && pstrb_i[0]
            && idx == pldc_pkg::IDX_MAC_PORT_CONTROL)
            |=> (rx_fifo_mid_level_o == $past(pwdata_i[6:5]));
    endproperty
    a_rx_mid: assert property (p_rx_mid)
        else $error("receive threshold write lost");

    property p_tx_mid;
        (access && pwrite_i && mapped && pstrb_i[0]
            && idx == pldc_pkg::IDX_MAC_PORT_CONTROL)
            |=> (tx_fifo_mid_level_o == $past(pwdata_i[4:3]));
    endproperty
    a_tx_mid: assert property (p_tx_mid)
        else $error("transmit threshold write lost");

    property p_read_clear;
        (access && !pwrite_i && mapped && hit == 5'h00
            && idx == pldc_pkg::IDX_FAST_DROP_CONFIG)
            |=> ((s.cause & $past(s.prdata[12:8])) == 5'h00);
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("cause flag not cleared by read");

endmodule

/* tb/tb_phy_link_drop_config_regs.sv */
// Self-checking bench for the quick link drop register bank
`timescale 1ns/1ps
module tb_phy_link_drop_config_regs;
    logic                    mclk_i;
    logic                    nrst_i;
    logic                    psel_i;
    logic                    penable_i;
    logic                    pwrite_i;
    logic [9:0]              paddr_i;
    logic [31:0]             pwdata_i;
    logic [31:0]             prdata_o;
    logic                    pready_o;
    logic                    pslverr_o;
    pldc_pkg::pldc_det_type  det_i;
    pldc_pkg::pldc_strap_type strap_i;
    logic                    start_i;
    logic                    drop_o;
    logic                    test_o;
    logic                    req_n_o;
    logic                    mirror_o;
    logic                    mac_o;
    logic [1:0]              rx_mid_o;
    logic [1:0]              tx_mid_o;
    logic                    done_o;
    logic                    irq_o;
    int                      miscompares = 0;
    int                      checks = 0;
    logic [31:0]             rd;
    logic                    er;

    // Short counts keep the slow timer selections cheap
    pldc_regs #(.CYC_800US(40), .CYC_11MS(60), .CYC_16MS(80)) dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(4'h3), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .det_i(det_i),
        .strap_i(strap_i), .neg_timer_start_i(start_i),
        .link_drop_o(drop_o), .int_test_mode_o(test_o),
        .test_entry_req_n_o(req_n_o), .port_mirror_o(mirror_o),
        .mac_if_enable_o(mac_o), .rx_fifo_mid_level_o(rx_mid_o),
        .tx_fifo_mid_level_o(tx_mid_o), .neg_timer_done_o(done_o),
        .irq_o(irq_o));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s exp %h got %h", nm, exp, got);
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= {16'h0, wd};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    // Let registered outputs land, then look mid-cycle
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    task automatic t_reset_values();
        apb(0, pldc_pkg::IDX_FAST_DROP_CONFIG, 0);
        chk("cfg", rd, 32'h0);
        apb(0, pldc_pkg::IDX_FAST_DROP_THRESHOLD, 0);
        chk("thr", rd, 32'h0222);
        apb(1, pldc_pkg::IDX_FAST_DROP_THRESHOLD, 16'h0221);
        apb(0, pldc_pkg::IDX_FAST_DROP_THRESHOLD, 0);
        chk("thr rewrite", rd, 32'h0221);
        apb(0, pldc_pkg::IDX_GENERAL_CONFIG_FOUR, 0);
        chk("general_config_four", rd, 32'h10b1);
        chk("req_n", req_n_o, 0);
        chk("test mode", test_o, 1);
        chk("mirror", mirror_o, 1);
        apb(0, pldc_pkg::IDX_MAC_PORT_CONTROL, 0);
        chk("mac", rd, 32'hd0);
        chk("tx_mid", tx_mid_o, 2'h2);
        apb(0, 8'h40, 0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
    endtask

    task automatic t_writes();
        apb(1, pldc_pkg::IDX_GENERAL_CONFIG_FOUR, 16'h0000);
        apb(0, pldc_pkg::IDX_GENERAL_CONFIG_FOUR, 0);
        chk("general_config_four fixed", rd, 32'h1010);
        chk("test", {test_o, mirror_o}, 2'b00);
        apb(1, pldc_pkg::IDX_MAC_PORT_CONTROL, 16'h0028);
        settle(0);
        chk("mac out", {mac_o, rx_mid_o, tx_mid_o}, 5'h05);
    endtask

    // Enabled rx errors drop; disabled mlt3 source must not latch
    task automatic t_drop_and_irq();
        apb(0, pldc_pkg::IDX_IRQ_STATUS, 0);
        // enable only once the link is up
        apb(1, pldc_pkg::IDX_FAST_DROP_CONFIG, 16'h4008);
        det_i.rx_errors <= 1'b1;
        det_i.mlt3_errors <= 1'b1;
        settle(2);
        chk("drop", drop_o, 1);
        @(posedge mclk_i);
        det_i.rx_errors <= 1'b0;
        det_i.mlt3_errors <= 1'b0;
        settle(2);
        chk("drop off", drop_o, 0);
        apb(1, pldc_pkg::IDX_IRQ_MASK, 16'h0008);
        settle(0);
        chk("irq", irq_o, 1);
        apb(0, pldc_pkg::IDX_FAST_DROP_CONFIG, 0);
        chk("cause", rd, 32'h4808);
        apb(0, pldc_pkg::IDX_FAST_DROP_CONFIG, 0);
        chk("cause clr", rd, 32'h4008);
        apb(0, pldc_pkg::IDX_IRQ_STATUS, 0);
        chk("irq sts", rd, 32'h08);
        settle(0);
        chk("irq clr", irq_o, 0);
        apb(1, pldc_pkg::IDX_FAST_DROP_CONFIG, 16'h4001);
        det_i.energy_acc <= 8'h00;
        settle(2);
        @(posedge mclk_i);
        det_i.energy_acc <= 8'hff;
        apb(0, pldc_pkg::IDX_FAST_DROP_CONFIG, 0);
        chk("energy", rd, 32'h4101);
        apb(1, pldc_pkg::IDX_FAST_DROP_CONFIG, 16'h8000);
        det_i.no_signal <= 1'b1;
        settle(2);
        chk("force", drop_o, 1);
        @(posedge mclk_i);
        det_i.no_signal <= 1'b0;
    endtask

    // Every selection; slow ones use the scaled counts 40, 60 and 80
    task automatic t_timer();
        int n;
        int e;
        for (int s = 0; s <= 3; s++) begin
            e = (s == 0) ? 81 : (s == 1) ? 21 : (s == 2) ? 41 : 61;
            apb(1, pldc_pkg::IDX_GENERAL_CONFIG_FOUR, 16'(s << 5));
            @(posedge mclk_i);
            start_i <= 1'b1;
            @(posedge mclk_i);
            start_i <= 1'b0;
            n = 0;
            do begin
                @(negedge mclk_i);
                n++;
            end while (done_o !== 1'b1 && n < 100);
            chk("timer", n, e);
            if (n >= 100) begin
                report_and_stop();
            end
            settle(0);
            chk("pulse", done_o, 0);
        end
        // Timer completion is a sticky status event
        apb(0, pldc_pkg::IDX_IRQ_STATUS, 0);
        chk("timer sts", rd & 32'h20, 32'h20);
    endtask

    // Mid-run reset with other straps; they reload after release
    task automatic t_restrap();
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        strap_i <= '{rx_ctrl: pldc_pkg::RXC_MODE2, default: 1'b0};
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        apb(0, pldc_pkg::IDX_FAST_DROP_THRESHOLD, 0);
        chk("thr reset", rd, 32'h0221);
        chk("strap", {test_o, req_n_o, mirror_o}, 3'b100);
    endtask

    initial begin
        nrst_i = 1'b0;
        {psel_i, penable_i, pwrite_i, start_i} = 4'h0;
        paddr_i = 10'h000;
        pwdata_i = 32'h0;
        det_i = '{energy_acc: 8'hff, default: 1'b0};
        strap_i = '{rx_ctrl: pldc_pkg::RXC_MODE1, mirror: 1'b1,
                    drop_enable: 1'b1, default: 1'b0};
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
        // Straps are loaded a few edges after release
        repeat (5) @(posedge mclk_i);
        t_reset_values();
        t_writes();
        t_drop_and_irq();
        t_timer();
        t_restrap();
        report_and_stop();
    end
endmodule
